// [logic/drive_status_fault_log.v]
// drive status word, fault history buffer, identification and unit reset request
// Notes on behaviour
// R1: bits 4 and 5 read 1 unless coast stop or quick stop is active.
// R2: bit 6 reads 1 while switch-on inhibit is active.
// R3: bit 12 shows brake control command, bit 13 brake status.
// R4: bits 0,1,2,4,5,6,9 copied into cyclic status word one.
// R5: with safety brake function active, brake not driven from bit 13.
// R6: 16-bit change counter increments on every fault buffer change.
// R7: 64 entries; indices 0..7 active incident, oldest at index 0.
// R8: beyond eight active faults, only index 7 is overwritten.
// R9: acknowledge shifts incidents one older; oldest incident discarded.
// R10: indices 8..63 hold seven acknowledged incidents of eight entries.
// R11: each entry records 32-bit millisecond runtime plus a day count.
// R12: each entry carries a signed 32-bit fault value, code and number.
// R13: 16-bit fault situation counter counts incidents, reset to 0.
// R14: writing zero to situation counter clears the fault buffer.
// R15: power-cycle faults survive a clear until power-on.
// R16: identification is seven words: company, type, version, dates, reserved, patch.
// R17: reserved identification word at index 5 reads 1.
// R18: reset request accepts 0..3, resets to 0; 0 means inactive.
// R19: value 1 resets immediately; refused while drive in operation.
// R20: controller writes 2, reads back, then writes 1.
// R21: value 3 resets on cyclic link loss, or at once if inactive.
// R22: after restart request reads 0 if reset done, nonzero otherwise.
// R23: one-cycle acknowledge strobe shifts incidents and bumps change counter.
`timescale 1ns/1ps
`include "drive_status_fault_log_defines.vh"

module drive_status_fault_log #(
  parameter [15:0] COMPANY_CODE = 16'h0001, // arbitrary value
  parameter [15:0] DEVICE_TYPE = 16'h0002, // arbitrary value
  parameter [15:0] FW_VERSION = 16'h0000,
  parameter [15:0] FW_YEAR = 16'h0000,
  parameter [15:0] FW_DAY_MONTH = 16'h0000,
  parameter [15:0] FW_PATCH = 16'h0000
) (
  input wire clock, // system clock
  input wire reset, // synchronous, active high
  input wire power_on_reset, // high only for a true power-on
  // sequence control inputs
  input wire ready_on, // ready for switching on
  input wire ready, // ready
  input wire op_enabled, // operation enabled
  input wire jog_active, // jog active
  input wire coast_stop, // coast stop active
  input wire quick_stop, // quick stop active
  input wire inhibit_active, // switch-on inhibited
  input wire drive_ready, // drive ready
  input wire ctrl_enable, // controller enable
  input wire ctrl_requested, // control requested
  input wire pulses_enabled, // pulses enabled
  input wire brake_cmd, // holding brake command
  input wire brake_state, // holding brake status
  input wire safety_brake_function, // safety brake enabled and selected
  // fault sources
  input wire fault_valid, // one-cycle new fault
  input wire [15:0] fault_code_in, // fault code
  input wire [15:0] fault_number_in, // fault number
  input wire [31:0] fault_value_in, // signed supplementary value
  input wire fault_power_cycle, // fault needs power-on acknowledge
  input wire [31:0] runtime_ms, // runtime milliseconds
  input wire [15:0] runtime_days, // runtime days
  input wire ack_strobe, // one-cycle incident acknowledge
  // link state
  input wire cyclic_active, // cyclic communication running
  // parameter access
  input wire param_write, // write strobe
  input wire param_read, // read strobe
  input wire [3:0] param_select, // parameter select
  input wire [5:0] param_index, // array index
  input wire [15:0] param_wdata, // write data
  output reg [31:0] param_rdata, // read data
  output reg param_ack, // access answered
  output reg param_refused, // write refused
  output reg [15:0] status_word, // full status word
  output reg [15:0] cyclic_status_word, // cyclic status word one
  output reg brake_drive, // brake drive from status path
  output reg hw_reset_req // hardware reset pulse
);

  reg [15:0] code_mem [0:`ENTRIES-1];
  reg [15:0] number_mem [0:`ENTRIES-1];
  reg [31:0] time_mem [0:`ENTRIES-1];
  reg [15:0] days_mem [0:`ENTRIES-1];
  reg [31:0] value_mem [0:`ENTRIES-1];
  reg pc_mem [0:`ENTRIES-1];
  reg [15:0] change_count_reg;
  reg [15:0] situation_reg;
  reg [15:0] reset_request_reg;
  reg [3:0] active_count_reg;
  reg executed_reg;
  wire clear_req;
  wire [2:0] slot;
  wire buf_change;
  integer i;

  // identification lookup
  function [15:0] ident_word;
    input [5:0] idx;
    begin
      case (idx)
        6'h00: ident_word = COMPANY_CODE;
        6'h01: ident_word = DEVICE_TYPE;
        6'h02: ident_word = FW_VERSION;
        6'h03: ident_word = FW_YEAR;
        6'h04: ident_word = FW_DAY_MONTH;
        6'h05: ident_word = `ID_RESERVED_VALUE; // [R17]
        6'h06: ident_word = FW_PATCH; // [R16]
        default: ident_word = 16'h0000;
      endcase
    end
  endfunction

  assign clear_req = param_write && param_select == `SEL_SITUATION_COUNT &&
    param_wdata == 16'h0000;
  // overflow faults land in the last active slot
  assign slot = (active_count_reg[3]) ? `ACTIVE_LAST : active_count_reg[2:0]; // [R8]
  assign buf_change = fault_valid || ack_strobe || clear_req;

  // status words and brake path
  always @(posedge clock) begin
    if (reset) begin
      status_word <= 16'h0000;
      cyclic_status_word <= 16'h0000;
      brake_drive <= 1'b0;
    end else begin
      status_word <= {2'b00, brake_state, brake_cmd, pulses_enabled, 1'b0, ctrl_requested,
        ctrl_enable, drive_ready, inhibit_active, ~quick_stop, ~coast_stop,
        jog_active, op_enabled, ready, ready_on}; // [R1] [R2] [R3]
      cyclic_status_word <= {6'h00, ctrl_requested, 2'b00, inhibit_active, ~quick_stop,
        ~coast_stop, 1'b0, op_enabled, ready, ready_on}; // [R4]
      brake_drive <= safety_brake_function ? 1'b0 : brake_state; // [R5]
    end
  end

  // fault buffer storage
  always @(posedge clock) begin
    if (reset) begin
      active_count_reg <= 4'h0;
      for (i = 0; i < `ENTRIES; i = i + 1) begin
        code_mem[i] <= 16'h0000;
        number_mem[i] <= 16'h0000;
        time_mem[i] <= 32'h0000_0000;
        days_mem[i] <= 16'h0000;
        value_mem[i] <= 32'h0000_0000;
        pc_mem[i] <= 1'b0;
      end
    end else if (clear_req) begin
      // clear all but power-cycle faults unless a power-on happened
      for (i = 0; i < `ENTRIES; i = i + 1) begin
        if (!pc_mem[i] || power_on_reset) begin // [R14] [R15]
          code_mem[i] <= 16'h0000;
          number_mem[i] <= 16'h0000;
          time_mem[i] <= 32'h0000_0000;
          days_mem[i] <= 16'h0000;
          value_mem[i] <= 32'h0000_0000;
          pc_mem[i] <= 1'b0;
        end
      end
      active_count_reg <= 4'h0;
    end else if (ack_strobe) begin
      // shift entries eight places older, drop the oldest incident
      for (i = `ENTRIES - 1; i >= 8; i = i - 1) begin // [R9] [R10] [R23]
        code_mem[i] <= code_mem[i-8];
        number_mem[i] <= number_mem[i-8];
        time_mem[i] <= time_mem[i-8];
        days_mem[i] <= days_mem[i-8];
        value_mem[i] <= value_mem[i-8];
        pc_mem[i] <= pc_mem[i-8];
      end
      for (i = 0; i < 8; i = i + 1) begin
        code_mem[i] <= 16'h0000;
        number_mem[i] <= 16'h0000;
        time_mem[i] <= 32'h0000_0000;
        days_mem[i] <= 16'h0000;
        value_mem[i] <= 32'h0000_0000;
        pc_mem[i] <= 1'b0;
      end
      active_count_reg <= 4'h0;
    end else if (fault_valid) begin
      code_mem[slot] <= fault_code_in; // [R7] [R12]
      number_mem[slot] <= fault_number_in;
      value_mem[slot] <= fault_value_in;
      time_mem[slot] <= runtime_ms; // [R11]
      days_mem[slot] <= runtime_days;
      pc_mem[slot] <= fault_power_cycle;
      if (!active_count_reg[3]) begin
        active_count_reg <= active_count_reg + 4'h1;
      end
    end
  end

  // change counter and situation counter
  always @(posedge clock) begin
    if (reset) begin
      change_count_reg <= 16'h0000;
      situation_reg <= `SITUATION_RESET;
    end else begin
      if (buf_change) begin
        change_count_reg <= change_count_reg + 16'h0001; // [R6] [R23]
      end
      if (clear_req) begin
        situation_reg <= 16'h0000; // [R14]
      end else if (fault_valid && !ack_strobe && active_count_reg == 4'h0) begin
        situation_reg <= situation_reg + 16'h0001; // [R13]
      end
    end
  end

  // unit reset request state machine
  always @(posedge clock) begin
    if (reset) begin
      reset_request_reg <= `RESET_REQ_RESET; // [R18]
      hw_reset_req <= 1'b0;
      param_refused <= 1'b0;
      executed_reg <= 1'b0;
    end else begin
      hw_reset_req <= 1'b0;
      param_refused <= 1'b0;
      if (executed_reg) begin
        // cleared by the restart reset itself; stays until then
        reset_request_reg <= reset_request_reg; // [R22]
      end
      if (param_write && param_select == `SEL_RESET_REQUEST) begin
        if (param_wdata > `RESET_REQ_MAX) begin
          param_refused <= 1'b1; // [R18]
        end else if (param_wdata == `RESET_REQ_NOW && op_enabled) begin
          param_refused <= 1'b1; // [R19]
        end else begin
          reset_request_reg <= param_wdata; // [R20]
        end
      end else if (!executed_reg) begin
        if (reset_request_reg == `RESET_REQ_NOW) begin
          hw_reset_req <= 1'b1; // [R19]
          executed_reg <= 1'b1;
        end else if (reset_request_reg == `RESET_REQ_ON_LOSS && !cyclic_active) begin
          hw_reset_req <= 1'b1; // [R21]
          executed_reg <= 1'b1;
        end
      end
    end
  end

  // parameter read port
  always @(posedge clock) begin
    if (reset) begin
      param_rdata <= 32'h0000_0000;
      param_ack <= 1'b0;
    end else begin
      param_ack <= param_read || param_write;
      if (param_read) begin
        case (param_select)
          `SEL_STATUS_WORD: param_rdata <= {16'h0000, status_word};
          `SEL_CHANGE_COUNT: param_rdata <= {16'h0000, change_count_reg};
          `SEL_FAULT_CODE: param_rdata <= {16'h0000, code_mem[param_index]};
          `SEL_FAULT_NUMBER: param_rdata <= {16'h0000, number_mem[param_index]};
          `SEL_FAULT_TIME_MS: param_rdata <= time_mem[param_index];
          `SEL_FAULT_VALUE: param_rdata <= value_mem[param_index];
          `SEL_SITUATION_COUNT: param_rdata <= {16'h0000, situation_reg};
          `SEL_DEVICE_ID: param_rdata <= {16'h0000, ident_word(param_index)};
          `SEL_RESET_REQUEST: param_rdata <= {16'h0000, reset_request_reg}; // [R22]
          `SEL_FAULT_TIME_DAYS: param_rdata <= {16'h0000, days_mem[param_index]};
          default: param_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // drive_status_fault_log

// [logic/drive_status_fault_log_defines.vh]
// constants for the drive status and fault log register bank
`ifndef DRIVE_STATUS_FAULT_LOG_DEFINES_VH
`define DRIVE_STATUS_FAULT_LOG_DEFINES_VH
// parameter select codes
`define SEL_STATUS_WORD 4'h0
`define SEL_CHANGE_COUNT 4'h1
`define SEL_FAULT_CODE 4'h2
`define SEL_FAULT_NUMBER 4'h3
`define SEL_FAULT_TIME_MS 4'h4
`define SEL_FAULT_VALUE 4'h5
`define SEL_SITUATION_COUNT 4'h6
`define SEL_DEVICE_ID 4'h7
`define SEL_RESET_REQUEST 4'h8
`define SEL_FAULT_TIME_DAYS 4'h9
// status word bit positions
`define SW_READY_ON 0
`define SW_READY 1
`define SW_OP_ENABLED 2
`define SW_JOG 3
`define SW_NO_COAST 4
`define SW_NO_QUICK 5
`define SW_INHIBIT 6
`define SW_DRIVE_READY 7
`define SW_CTRL_ENABLE 8
`define SW_CTRL_REQ 9
`define SW_PULSES 11
`define SW_BRAKE_CMD 12
`define SW_BRAKE_STATE 13
// reset values and limits
`define SITUATION_RESET 16'h0000
`define RESET_REQ_RESET 16'h0000
`define RESET_REQ_MAX 16'h0003
`define RESET_REQ_OFF 16'h0000
`define RESET_REQ_NOW 16'h0001
`define RESET_REQ_PREP 16'h0002
`define RESET_REQ_ON_LOSS 16'h0003
`define ID_RESERVED_VALUE 16'h0001
// buffer layout
`define ACTIVE_LAST 3'h7
`define ENTRIES 64
`endif

// [tb/drive_status_fault_log_checker.sv]
// port assertions for the drive status and fault log
`timescale 1ns/1ps
`include "drive_status_fault_log_defines.vh"
module drive_status_fault_log_checker (
  input wire clock, // system clock
  input wire reset, // synchronous reset
  input wire coast_stop, quick_stop, inhibit_active, // stop and inhibit inputs
  input wire brake_cmd, brake_state, safety_brake_function, // brake inputs
  input wire op_enabled, param_write, // operation state and write strobe
  input wire [3:0] param_select, // parameter select
  input wire [15:0] param_wdata, // write data
  input wire [15:0] status_word, cyclic_status_word, // status outputs
  input wire brake_drive, param_refused, hw_reset_req // brake, refusal and reset pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // write to the unit reset request
  wire req_wr = param_write && param_select == `SEL_RESET_REQUEST;
  stop_bits_a: assert property (!$past(reset) |->
    status_word[5:4] == ~{$past(quick_stop), $past(coast_stop)}) else $error("stop bits wrong");
  inhibit_bit_a: assert property (!$past(reset) |->
    status_word[6] == $past(inhibit_active)) else $error("inhibit bit wrong");
  brake_bits_a: assert property (!$past(reset) |->
    status_word[13:12] == {$past(brake_state), $past(brake_cmd)}) else $error("brake bits wrong");
  cyclic_copy_a: assert property (
    cyclic_status_word == (status_word & 16'h0277)) else $error("cyclic word wrong");
  safe_brake_a: assert property (!$past(reset) && $past(safety_brake_function) |->
    !brake_drive) else $error("brake driven under safety function");
  now_refused_a: assert property (req_wr && param_wdata == 16'h0001 && op_enabled |=>
    param_refused ##1 !hw_reset_req) else $error("reset in operation not refused");
  range_refused_a: assert property (req_wr && param_wdata > 16'h0003 |=>
    param_refused) else $error("out of range value not refused");
  now_reset_a: assert property (req_wr && param_wdata == 16'h0001 && !op_enabled |=>
    !param_refused ##1 hw_reset_req) else $error("immediate reset missing");
endmodule // drive_status_fault_log_checker
bind drive_status_fault_log drive_status_fault_log_checker
  drive_status_fault_log_checker_inst (.*);

// [tb/drive_status_fault_log_tb_top.sv]
// self-checking bench for the drive status and fault log
`timescale 1ns/1ps
`include "drive_status_fault_log_defines.vh"
module drive_status_fault_log_tb_top;
  reg clock = 0, reset = 1, power_on_reset = 0, safety_brake_function = 0, cyclic_active = 0;
  reg ready_on, ready, op_enabled, jog_active, coast_stop, quick_stop, inhibit_active;
  reg drive_ready, ctrl_enable, ctrl_requested, pulses_enabled, brake_cmd, brake_state;
  reg fault_valid = 0, fault_power_cycle = 0, ack_strobe = 0;
  reg [15:0] fault_code_in = 0, fault_number_in = 0, runtime_days = 0, e;
  reg [31:0] fault_value_in = 0, runtime_ms = 0, q;
  wire param_write, param_read, param_ack, param_refused, brake_drive, hw_reset_req;
  wire [3:0] param_select;
  wire [5:0] param_index;
  wire [15:0] param_wdata, status_word, cyclic_status_word;
  wire [31:0] param_rdata;
  integer err_total = 0, n_checks = 0, cycles = 0, n_hw = 0, i;
  always #2.5 clock = ~clock;
  drive_status_fault_log drive_status_fault_log_inst (.*);
  param_controller param_controller_inst (.*);
  // cycle limit and count of reset pulses
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (hw_reset_req === 1'b1) n_hw = n_hw + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      test_done;
    end
  end
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task rc(input [3:0] s, input [5:0] x, input [31:0] exp);
    begin
      param_controller_inst.acc(1'b0, s, x, 16'h0000, q);
      chk($sformatf("sel %0h index %0d", s, x), exp, q);
      chk("param ack", 32'h1, {31'h0, param_ack});
    end
  endtask
  task wr(input [3:0] s, input [15:0] d);
    param_controller_inst.acc(1'b1, s, 6'h00, d, q);
  endtask
  task set_st(input [12:0] v);
    {brake_state, brake_cmd, pulses_enabled, ctrl_requested, ctrl_enable, drive_ready,
     inhibit_active, quick_stop, coast_stop, jog_active, op_enabled, ready, ready_on} = v;
  endtask
  task rst;
    begin
      @(negedge clock);
      reset = 1;
      repeat (2) @(negedge clock);
      reset = 0;
    end
  endtask
  task fault(input [15:0] c, input pc);
    begin
      @(negedge clock);
      {fault_valid, fault_code_in, fault_number_in, fault_power_cycle} = {1'b1, c, ~c, pc};
      fault_value_in = -{16'h0000, c};
      runtime_ms = {c, 16'h1234};
      runtime_days = c + 16'h0001;
      @(negedge clock);
      fault_valid = 0;
    end
  endtask
  task ack;
    begin
      @(negedge clock);
      ack_strobe = 1;
      @(negedge clock);
      ack_strobe = 0;
    end
  endtask
  task t_status;
    reg [12:0] v;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        v = i[1] ? (i[0] ? 13'h1fff : 13'h0000) : (i[0] ? 13'h1555 : 13'h0aaa);
        @(negedge clock);
        set_st(v);
        safety_brake_function = i[1];
        @(negedge clock);
        e = {2'b00, v[12:10], 1'b0, v[9:6], ~v[5:4], v[3:0]};
        chk("status word", e, status_word);
        chk("cyclic word", e & 16'h0277, cyclic_status_word);
        chk("brake drive", v[12] & ~i[1], brake_drive);
      end
      set_st(13'h0000);
      safety_brake_function = 0;
      rc(`SEL_DEVICE_ID, 6'd5, 32'h1);
      $display("status and identification test done");
    end
  endtask
  task t_buffer;
    begin
      for (i = 1; i <= 10; i = i + 1) fault(i, 1'b0);
      rc(`SEL_FAULT_CODE, 6'd0, 32'h1);
      rc(`SEL_FAULT_CODE, 6'd6, 32'h7);
      rc(`SEL_FAULT_CODE, 6'd7, 32'ha);
      rc(`SEL_FAULT_NUMBER, 6'd0, 32'hfffe);
      rc(`SEL_FAULT_VALUE, 6'd0, 32'hffffffff);
      rc(`SEL_FAULT_TIME_MS, 6'd0, 32'h00011234);
      rc(`SEL_FAULT_TIME_DAYS, 6'd0, 32'h2);
      rc(`SEL_CHANGE_COUNT, 6'd0, 32'd10);
      rc(`SEL_SITUATION_COUNT, 6'd0, 32'h1);
      ack;
      rc(`SEL_FAULT_CODE, 6'd8, 32'h1);
      rc(`SEL_FAULT_CODE, 6'd15, 32'ha);
      rc(`SEL_CHANGE_COUNT, 6'd0, 32'd11);
      fault(16'h0020, 1'b0);
      ack;
      rc(`SEL_FAULT_CODE, 6'd16, 32'h1);
      rc(`SEL_SITUATION_COUNT, 6'd0, 32'h2);
      repeat (5) ack;
      rc(`SEL_FAULT_CODE, 6'd63, 32'ha);
      ack;
      rc(`SEL_FAULT_CODE, 6'd56, 32'h20);
      fault(16'h0030, 1'b1);
      wr(`SEL_SITUATION_COUNT, 16'h0000);
      rc(`SEL_FAULT_CODE, 6'd56, 32'h0);
      rc(`SEL_FAULT_CODE, 6'd0, 32'h30);
      power_on_reset = 1;
      wr(`SEL_SITUATION_COUNT, 16'h0000);
      rc(`SEL_FAULT_CODE, 6'd0, 32'h0);
      $display("fault buffer test done");
    end
  endtask
  task t_reset;
    begin
      rc(`SEL_RESET_REQUEST, 6'd0, 32'h0);
      op_enabled = 1;
      wr(`SEL_RESET_REQUEST, 16'h0001);
      chk("refused", 32'h1, {31'h0, param_refused});
      wr(`SEL_RESET_REQUEST, 16'h0004);
      chk("refused", 32'h1, {31'h0, param_refused});
      rc(`SEL_RESET_REQUEST, 6'd0, 32'h0);
      op_enabled = 0;
      param_controller_inst.prep(q);
      chk("prepare readback", 32'h2, q);
      repeat (3) @(negedge clock);
      chk("reset pulses", 32'd1, n_hw);
      rc(`SEL_RESET_REQUEST, 6'd0, 32'h1);
      rst;
      rc(`SEL_RESET_REQUEST, 6'd0, 32'h0);
      cyclic_active = 1;
      wr(`SEL_RESET_REQUEST, 16'h0003);
      repeat (5) @(negedge clock);
      chk("reset pulses", 32'd1, n_hw);
      cyclic_active = 0;
      repeat (3) @(negedge clock);
      chk("reset pulses", 32'd2, n_hw);
      rst;
      wr(`SEL_RESET_REQUEST, 16'h0003);
      repeat (3) @(negedge clock);
      chk("reset pulses", 32'd3, n_hw);
      $display("unit reset test done");
    end
  endtask
  // main sequence
  initial begin
    set_st(13'h0000);
    repeat (2) @(negedge clock);
    reset = 0;
    t_status;
    t_buffer;
    t_reset;
    test_done;
  end
endmodule // drive_status_fault_log_tb_top

// [tb/param_controller.sv]
// controller model issuing parameter reads and writes
`timescale 1ns/1ps
module param_controller (
  input wire clock, // system clock
  input wire [31:0] param_rdata, // read data
  output reg param_write, // write strobe
  output reg param_read, // read strobe
  output reg [3:0] param_select, // parameter select
  output reg [5:0] param_index, // array index
  output reg [15:0] param_wdata // write data
);
  initial {param_write, param_read, param_select, param_index, param_wdata} = 28'h0;
  // one access: strobe for one cycle, answer taken one cycle later
  task acc(input w, input [3:0] s, input [5:0] i, input [15:0] d, output [31:0] q);
    begin
      @(negedge clock);
      {param_write, param_read, param_select, param_index, param_wdata} = {w, !w, s, i, d};
      @(negedge clock);
      {param_write, param_read} = 2'b00;
      param_wdata = ~d; // no stale data left on the lines
      q = param_rdata;
    end
  endtask
  // checked unit reset: prepare, read back, trigger
  task prep(output [31:0] q);
    reg [31:0] unused;
    begin
      acc(1'b1, 4'h8, 6'h00, 16'h0002, unused);
      acc(1'b0, 4'h8, 6'h00, 16'h0000, q);
      acc(1'b1, 4'h8, 6'h00, 16'h0001, unused);
    end
  endtask
endmodule // param_controller
